// ===== bench/sec_ctrl_sva.sv
`include "sec_regs.svh"

module sec_ctrl_sva #(
    parameter int TIMEOUT_CYC = 2000, // Give-up count
    parameter int LOAD_BYTES = 4 // Bytes per load
) (
    input logic clk, // Clock
    input logic reset_n, // Reset
    input logic [7:0] reg_addr, // Address
    input logic reg_rd, // Read strobe
    input logic [31:0] reg_rdata, // Read data
    input logic mem_cs, // Select
    input logic mem_sk, // Serial clock
    input logic mem_di, // Serial data
    input logic cfg_load_wr, // Load pulse
    input logic [8:0] cfg_load_addr // Load address
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] cs_run_q, cs_run_d;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    // Length of the current select-high run, bounded by the give-up count
    always_comb cs_run_d = mem_cs ? cs_run_q + 32'h1 : 32'h0;
    always_ff @(posedge clk) cs_run_q <= reset_n ? cs_run_d : 32'h0;
    sequence s_rd(ofs);
        $past(reg_rd) && $past(reg_addr) == ofs;
    endsequence
    sequence s_load;
        cfg_load_wr ##1 !cfg_load_wr;
    endsequence
    chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data outside answer cycle");
    chk_data_upper: assert property (s_rd(`SEC_DATA_OFS) |-> reg_rdata[31:8] == 24'h0)
        else $error("data upper bits set");
    chk_cmd_resv: assert property (s_rd(`SEC_CMD_OFS) |-> reg_rdata[27:11] == 17'h0)
        else $error("command reserved bits set");
    chk_load_start: assert property ($rose(reset_n) |-> ##[1:4] mem_cs)
        else $error("no load after reset");
    chk_sk_in_cs: assert property (mem_sk |-> mem_cs)
        else $error("serial clock outside frame");
    chk_di_edge: assert property (mem_cs && $past(mem_cs) &&
        $changed(mem_di) |-> $fell(mem_sk) || !$past(mem_cs, 2))
        else $error("data moved off falling clock");
    chk_cs_gap: assert property ($fell(mem_cs) |=> !mem_cs)
        else $error("select gap too short");
    chk_load_addr: assert property (cfg_load_wr |-> cfg_load_addr >= 9'h001 && cfg_load_addr < LOAD_BYTES)
        else $error("load address out of range");
    chk_load_pulse: assert property (cfg_load_wr |-> s_load)
        else $error("load strobe too long");
    chk_tmo_bound: assert property (cs_run_q <= TIMEOUT_CYC)
        else $error("operation outlived time-out");
endmodule

// ===== bench/sec_mem_model.sv
module sec_mem_model (
    input wire logic cs, // Select
    input wire logic sk, // Serial clock
    input wire logic di, // Data in
    input wire logic present, // Device fitted
    input wire logic pull_hi, // Board pull level
    input wire logic [15:0] busy_ns, // Program time
    output logic dout // Data out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] mem [512];
    logic [19:0] sh = 20'h0;
    logic [11:0] hdr = 12'h0;
    logic [7:0] ob = 8'h00;
    logic ew_en = 1'b0; // Powers up write-protected
    logic drv = 1'b0;
    logic val = 1'b0;
    logic pend = 1'b0;
    int n = 0;
    time t_rdy = 0;
    // Released or missing device leaves the line at the board pull
    assign dout = (present && drv) ? val : pull_hi;
    // Shift in start bit, opcode, address and write data
    always @(posedge sk) if (cs && present) begin
        sh = {sh[18:0], di};
        n++;
        if (n == 12) hdr = sh[11:0];
        if (n == 12 && sh[10:9] == 2'b10) begin
            ob = mem[sh[8:0]];
            drv = 1'b1;
            val = 1'b0; // Dummy zero ahead of data
        end
    end
    // Read data moves on the falling clock so the high phase is stable
    always @(negedge sk) if (cs && drv && n >= 12) begin
        val = ob[7];
        ob = ob << 1;
    end
    // End of frame: run erase or write, or end a ready poll
    always @(negedge cs) begin
        drv = 1'b0;
        if (pend)
            pend = 1'b0;
        else if (ew_en && ((n == 12 && (hdr[10:9] == 2'b11 ||
                 hdr[10:7] == 4'b0010)) || (n == 20 &&
                 (hdr[10:9] == 2'b01 || hdr[10:7] == 4'b0001)))) begin
            foreach (mem[i])
                if (hdr[10:9] == 2'b00 || i == hdr[8:0])
                    mem[i] = (n == 12) ? 8'hFF : sh[7:0];
            pend = 1'b1;
            t_rdy = $time + busy_ns;
        end
        if (n == 12 && hdr[10:7] == 4'b0011) ew_en = 1'b1;
        if (n == 12 && hdr[10:7] == 4'b0000) ew_en = 1'b0;
        n = 0;
    end
    // Ready status shows while selected after a program start; the
    // update step is kept off the system clock's rising edges
    always @(posedge cs) if (pend) drv = 1'b1;
    always #4 if (pend) val = ($time >= t_rdy);
endmodule

// ===== bench/tb.sv
`include "sec_regs.svh"

module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import sec_pkg::*;
    localparam int TMO = 2000;
    localparam int NLD = 4;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata, q;
    logic mem_cs, mem_sk, mem_di, din, cfg_load_wr, irq, tm;
    logic [8:0] cfg_load_addr, a;
    logic [7:0] cfg_load_data, d;
    logic present = 1'b1;
    logic pull_hi = 1'b1;
    logic [15:0] busy_ns = 16'h0;
    logic [7:0] img [512];
    logic en = 1'b0;
    int err_total = 0;
    int n_compared = 0;
    int loads = 0;
    int cyc;
    time t0;
    sec_cmd_t ops [9];

    sec_ctrl #(.TIMEOUT_CYC(TMO), .SK_HALF(2), .LOAD_BYTES(NLD)) u_sec_ctrl (
        .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .mem_cs(mem_cs), .mem_sk(mem_sk),
        .mem_di(mem_di), .serial_mem_data_in(din),
        .cfg_load_wr(cfg_load_wr), .cfg_load_addr(cfg_load_addr),
        .cfg_load_data(cfg_load_data), .irq(irq));
    sec_mem_model u_sec_mem_model (.cs(mem_cs), .sk(mem_sk), .di(mem_di),
        .present(present), .pull_hi(pull_hi), .busy_ns(busy_ns), .dout(din));

    // System clock
    always #5 clk = ~clk;

    task automatic chk(input logic [31:0] g, input logic [31:0] e,
                       input string m);
        n_compared++;
        if (g !== e) begin
            err_total++;
            $display("ERROR %0t %s got %h exp %h", $time, m, g, e);
        end
    endtask

    // One-cycle strobes, then a quiet edge so strobes never double up
    task automatic wr(input logic [7:0] ad, input logic [31:0] v);
        reg_addr <= ad;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [7:0] ad);
        reg_addr <= ad;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 q = reg_rdata;
        @(posedge clk);
    endtask

    // Poll busy under a bound, then check the outcome flags
    task automatic waitb(input logic tmo);
        for (int i = 0; i < 1500 && q[31] !== 1'b0; i++)
            rd(`SEC_CMD_OFS);
        cyc = int'(($time - t0) / 10);
        chk(32'(q[31]), 32'h0, "busy stuck");
        chk(32'(q[10]), 32'(tmo), "timeout flag");
    endtask

    // Data register poked while busy must be ignored
    task automatic run(input sec_cmd_t op, input logic [8:0] ad,
                       input logic [7:0] dv, input logic tmo);
        wr(`SEC_DATA_OFS, {24'hA5A5A5, dv});
        wr(`SEC_CMD_OFS, {1'b1, op, 19'h0, ad});
        t0 = $time;
        wr(`SEC_DATA_OFS, 32'(~dv));
        rd(`SEC_CMD_OFS);
        chk(32'(q[31]), 32'h1, "busy held");
        waitb(tmo);
    endtask

    function automatic logic [7:0] after(input sec_cmd_t op,
        input logic [7:0] old, input logic [7:0] dv, input logic hit);
        if (!en)
            return old;
        case (op)
            CMD_WRITE: return hit ? dv : old;
            CMD_WRITE_ALL: return dv;
            CMD_ERASE: return hit ? 8'hFF : old;
            CMD_ERASE_ALL: return 8'hFF;
            default: return old;
        endcase
    endfunction

    task automatic final_report;
        $display("Compared %0d errors %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Each loaded byte must match the memory image
    always @(posedge clk) if (cfg_load_wr === 1'b1) begin
        loads++;
        chk(32'(cfg_load_data), 32'(img[cfg_load_addr]), "load data");
    end

    initial begin
        q = $urandom(82);
        foreach (img[i]) img[i] = 8'($urandom);
        img[0] = `SEC_SIGNATURE;
        foreach (img[i]) u_sec_mem_model.mem[i] = img[i];
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        t0 = $time;
        rd(`SEC_CMD_OFS);
        chk(32'(q[31]), 32'h1, "busy at reset");
        waitb(1'b0);
        chk(32'(loads), NLD - 1, "load count");
        chk(32'(q[9:0]), 32'h200, "loaded, address zero");
        rd(`SEC_DATA_OFS);
        chk(q, 32'h0, "data reset");
        rd(8'h40);
        chk(q, 32'h0, "unmapped read");
        rd(`SEC_ISTS_OFS);
        chk(q, 32'h5, "load status");
        chk(32'(irq), 32'h0, "irq masked");
        wr(`SEC_IMSK_OFS, 32'h4);
        #1 chk(32'(irq), 32'h1, "irq raised");
        wr(`SEC_ISTS_OFS, 32'h4);
        #1 chk(32'(irq), 32'h0, "irq cleared");
        wr(`SEC_ISTS_OFS, 32'h7);
        wr(`SEC_IMSK_OFS, 32'h2);
        ops = '{CMD_EW_ENABLE, CMD_WRITE, CMD_ERASE, CMD_WRITE_ALL, CMD_WRITE,
                CMD_ERASE_ALL, CMD_EW_DISABLE, CMD_WRITE, CMD_ERASE};
        // Each command against a shadow image, then a read back
        foreach (ops[k]) begin
            a = 9'($urandom);
            d = 8'($urandom);
            busy_ns <= ($urandom % 2) ? 16'h0BB8 : 16'h0000;
            run(ops[k], a, d, 1'b0);
            rd(`SEC_DATA_OFS);
            chk(q, 32'(d), "data kept");
            foreach (img[i]) img[i] = after(ops[k], img[i], d, i == a);
            if (ops[k] == CMD_EW_ENABLE) en = 1'b1;
            if (ops[k] == CMD_EW_DISABLE) en = 1'b0;
            a = ($urandom % 2) ? a : 9'($urandom);
            run(CMD_READ, a, ~d, 1'b0);
            rd(`SEC_DATA_OFS);
            chk(q, 32'(img[a]), "read back");
        end
        // Missing device, line pulled low then high, every command
        wr(`SEC_CMD_OFS, 32'h200);
        present <= 1'b0;
        for (int p = 0; p < 2; p++) begin
            pull_hi <= p[0];
            for (int o = 0; o < 8; o++) begin
                tm = (p == 0) && (o >= 3) && (o <= 6);
                run(sec_cmd_t'(o), 9'($urandom), 8'h00, tm);
                if (tm) begin
                    chk(32'(cyc > TMO - 4 && cyc < TMO + 40), 32'h1, "tmo time");
                    chk(32'(irq), 32'h1, "tmo irq");
                    wr(`SEC_ISTS_OFS, 32'h2);
                end else
                    chk(32'(cyc < 300), 32'h1, "quick end");
            end
        end
        present <= 1'b1;
        img[0] = `SEC_SIGNATURE;
        u_sec_mem_model.mem[0] = img[0];
        run(CMD_RELOAD, 9'h000, 8'h00, 1'b0);
        chk(32'(q[9]), 32'h1, "reload");
        chk(32'(loads), 2 * NLD - 2, "reload count");
        // A failed reload must leave the loaded bit set as it was
        u_sec_mem_model.mem[0] = 8'hFF;
        run(CMD_RELOAD, 9'h000, 8'h00, 1'b0);
        chk(32'(q[9]), 32'h1, "failed reload");
        chk(32'(loads), 2 * NLD - 2, "no bytes loaded");
        final_report;
    end

    // Cuts a hang well past the expected run length
    initial begin
        #600000;
        err_total++;
        $display("ERROR %0t watchdog expired", $time);
        final_report;
    end
endmodule

bind sec_ctrl sec_ctrl_sva #(.TIMEOUT_CYC(TIMEOUT_CYC),
    .LOAD_BYTES(LOAD_BYTES)) u_sva (.clk(clk), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .mem_cs(mem_cs), .mem_sk(mem_sk), .mem_di(mem_di),
    .cfg_load_wr(cfg_load_wr), .cfg_load_addr(cfg_load_addr));

// ===== include/sec_pkg.sv
package sec_pkg;

    // Command field encoding
    typedef enum logic [2:0] {
        CMD_READ = 3'h0,
        CMD_EW_DISABLE = 3'h1,
        CMD_EW_ENABLE = 3'h2,
        CMD_WRITE = 3'h3,
        CMD_WRITE_ALL = 3'h4,
        CMD_ERASE = 3'h5,
        CMD_ERASE_ALL = 3'h6,
        CMD_RELOAD = 3'h7
    } sec_cmd_t;

    // Controller sequencing, one-hot
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_SEND = 5'h02,
        ST_GAP = 5'h04,
        ST_POLL = 5'h08,
        ST_NEXT = 5'h10
    } sec_state_t;

endpackage

// ===== include/sec_regs.svh
`ifndef SEC_REGS_SVH
`define SEC_REGS_SVH

// Register byte offsets on the register port
`define SEC_CMD_OFS 8'h30
`define SEC_DATA_OFS 8'h34
`define SEC_ISTS_OFS 8'h58
`define SEC_IMSK_OFS 8'h5C

// Command register fields
`define SEC_BUSY_BIT 31
`define SEC_OP_HI 30
`define SEC_OP_LO 28
`define SEC_TMO_BIT 10
`define SEC_LOADED_BIT 9
`define SEC_ADDR_HI 8
`define SEC_ADDR_RST 9'h000

// Data register fields
`define SEC_DATA_HI 7
`define SEC_DATA_RST 8'h00

// Interrupt status and mask bits
`define SEC_IRQ_W 3
`define SEC_IRQ_DONE 0
`define SEC_IRQ_TMO 1
`define SEC_IRQ_LOAD 2

// Marker that a programmed memory holds in its first location
`define SEC_SIGNATURE 8'hA5

// Serial frame layout: start bit, two opcode bits, nine address bits, eight data bits
`define SEC_FRAME_W 20
`define SEC_HDR_BITS 5'd12
`define SEC_FULL_BITS 5'd20
`define SEC_RX_BITS 4'd8

// Timing
`define SEC_CLK_MHZ 100
`define SEC_TIMEOUT_MS 30
`define SEC_TIMEOUT_CYC (`SEC_TIMEOUT_MS * 1000 * `SEC_CLK_MHZ)
`define SEC_SK_HALF_NS 500
`define SEC_SK_HALF_CYC ((`SEC_SK_HALF_NS * `SEC_CLK_MHZ + 999) / 1000)
`define SEC_LOAD_BYTES 16

`endif

// ===== rtl/sec_ctrl.sv
// The strobed register port was chosen for this implementation.
`include "sec_regs.svh"

module sec_ctrl #(
    parameter int TIMEOUT_CYC = `SEC_TIMEOUT_CYC, // Clocks before giving up
    parameter int SK_HALF = `SEC_SK_HALF_CYC, // Serial clock half period
    parameter int LOAD_BYTES = `SEC_LOAD_BYTES // Bytes read by a load
) (
    input logic clk, // System clock, 100 MHz
    input logic reset_n, // Synchronous reset, active low
    input logic [7:0] reg_addr, // Register byte address
    input logic [31:0] reg_wdata, // Register write data
    input logic reg_wr, // Register write strobe
    input logic reg_rd, // Register read strobe
    output logic [31:0] reg_rdata, // Read data, cycle after strobe
    output logic mem_cs, // Memory chip select
    output logic mem_sk, // Memory serial clock
    output logic mem_di, // Serial data to the memory
    input logic serial_mem_data_in, // Serial data from the memory
    output logic cfg_load_wr, // Pulse: one loaded configuration byte
    output logic [8:0] cfg_load_addr, // Memory address of that byte
    output logic [7:0] cfg_load_data, // Loaded byte
    output logic irq // Level interrupt
);
    import sec_pkg::*;

    // Serial word for a command: {length, frame}
    function automatic logic [`SEC_FRAME_W+4:0] frame_of(
        input sec_cmd_t op,
        input logic [8:0] a,
        input logic [7:0] d
    );
        logic [`SEC_FRAME_W-1:0] f;
        logic [4:0] n;
        f = '0;
        n = `SEC_HDR_BITS;
        case (op)
            CMD_READ: f = {3'b110, a, 8'h00};
            CMD_EW_DISABLE: f = {3'b100, 9'h000, 8'h00};
            CMD_EW_ENABLE: f = {3'b100, 9'h180, 8'h00};
            CMD_WRITE: begin
                f = {3'b101, a, d};
                n = `SEC_FULL_BITS;
            end
            CMD_WRITE_ALL: begin
                f = {3'b100, 9'h080, d};
                n = `SEC_FULL_BITS;
            end
            CMD_ERASE: f = {3'b111, a, 8'h00};
            CMD_ERASE_ALL: f = {3'b100, 9'h100, 8'h00};
            default: f = {3'b110, a, 8'h00};
        endcase
        return {n, f};
    endfunction

    // Commands that leave the memory busy and are polled for ready
    function automatic logic needs_poll(input sec_cmd_t op);
        return (op == CMD_WRITE) || (op == CMD_WRITE_ALL) ||
               (op == CMD_ERASE) || (op == CMD_ERASE_ALL);
    endfunction

    // Two-flop synchroniser for the memory data pin
    logic din_s1_q, din_s2_q;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            din_s1_q <= 1'b0;
            din_s2_q <= 1'b0;
        end else begin
            din_s1_q <= serial_mem_data_in;
            din_s2_q <= din_s1_q;
        end
    end

    // Controller state
    sec_state_t state_q, state_d;
    sec_cmd_t op_q, op_d;
    logic [8:0] addr_q, addr_d;
    logic [7:0] data_q, data_d;
    logic busy_q, busy_d;
    logic tmo_q, tmo_d;
    logic loaded_q, loaded_d;
    logic reload_q, reload_d;
    logic [8:0] idx_q, idx_d;
    logic [31:0] tmo_cnt_q, tmo_cnt_d;
    logic [15:0] gap_q, gap_d;
    logic [7:0] byte_q, byte_d;
    logic start_q, start_d;
    logic cs_q, cs_d;
    logic [`SEC_IRQ_W-1:0] ists_q, ists_d;
    logic [`SEC_IRQ_W-1:0] imsk_q, imsk_d;
    logic [31:0] rdata_q, rdata_d;
    logic lwr_q, lwr_d;
    logic [8:0] laddr_q, laddr_d;
    logic [7:0] ldata_q, ldata_d;

    // Frame engine connections
    logic [`SEC_FRAME_W+4:0] word;
    logic sh_done;
    logic [7:0] sh_rx;
    logic wr_cmd, wr_data, wr_ists, wr_imsk;
    logic [`SEC_IRQ_W-1:0] ev;

    // A reload is a read of the current load index
    assign word = reload_q ? frame_of(CMD_READ, idx_q, 8'h00)
                           : frame_of(op_q, addr_q, data_q);

    sec_shift #(
        .SK_HALF(SK_HALF)
    ) u_shift (
        .clk(clk),
        .reset_n(reset_n),
        .start(start_q),
        .frame(word[`SEC_FRAME_W-1:0]),
        .tx_len(word[`SEC_FRAME_W+4:`SEC_FRAME_W]),
        .rx_len((reload_q || op_q == CMD_READ) ? `SEC_RX_BITS : 4'd0),
        .din(din_s2_q),
        .sk(mem_sk),
        .dout(mem_di),
        .done(sh_done),
        .rx_byte(sh_rx)
    );

    // Register write decode
    assign wr_cmd = reg_wr && (reg_addr == `SEC_CMD_OFS);
    assign wr_data = reg_wr && (reg_addr == `SEC_DATA_OFS);
    assign wr_ists = reg_wr && (reg_addr == `SEC_ISTS_OFS);
    assign wr_imsk = reg_wr && (reg_addr == `SEC_IMSK_OFS);

    // Sequencer and software-visible fields
    always_comb begin
        state_d = state_q;
        op_d = op_q;
        addr_d = addr_q;
        data_d = data_q;
        busy_d = busy_q;
        tmo_d = tmo_q;
        loaded_d = loaded_q;
        reload_d = reload_q;
        idx_d = idx_q;
        tmo_cnt_d = tmo_cnt_q;
        gap_d = gap_q;
        byte_d = byte_q;
        start_d = 1'b0;
        lwr_d = 1'b0;
        laddr_d = laddr_q;
        ldata_d = ldata_q;
        ev = '0;

        // Address, opcode and data are frozen while a command runs (the loaded
        // bit can still be cleared), so a late write cannot
        // corrupt the frame being shifted
        if (wr_cmd && !busy_q) begin
            addr_d = reg_wdata[`SEC_ADDR_HI:0];
            op_d = sec_cmd_t'(reg_wdata[`SEC_OP_HI:`SEC_OP_LO]);
            if (reg_wdata[`SEC_BUSY_BIT]) begin
                busy_d = 1'b1;
                reload_d = (reg_wdata[`SEC_OP_HI:`SEC_OP_LO] == 3'h7);
                idx_d = 9'h000;
            end
        end
        if (wr_data && !busy_q) begin
            data_d = reg_wdata[`SEC_DATA_HI:0];
        end
        if (wr_cmd && reg_wdata[`SEC_LOADED_BIT]) begin
            loaded_d = 1'b0;
        end

        // Time-out interval counts system clocks while an operation runs
        if (state_q != ST_IDLE) begin
            tmo_cnt_d = tmo_cnt_q + 32'h1;
        end

        case (state_q)
            ST_IDLE: begin
                if (busy_q) begin
                    start_d = 1'b1;
                    tmo_cnt_d = 32'h0;
                    tmo_d = 1'b0;
                    state_d = ST_SEND;
                end
            end
            ST_SEND: begin
                if (sh_done) begin
                    if (reload_q) begin
                        byte_d = sh_rx;
                        state_d = ST_NEXT;
                    end else if (needs_poll(op_q)) begin
                        gap_d = 16'h0;
                        state_d = ST_GAP;
                    end else begin
                        // Nothing to wait for: done once shifted out
                        if (op_q == CMD_READ) begin
                            data_d = sh_rx;
                        end
                        busy_d = 1'b0;
                        ev[`SEC_IRQ_DONE] = 1'b1;
                        state_d = ST_IDLE;
                    end
                end
            end
            ST_GAP: begin
                // Select low for a serial half period between frames
                gap_d = gap_q + 16'h1;
                if (gap_q == 16'(SK_HALF - 1)) begin
                    state_d = (reload_q) ? ST_IDLE : ST_POLL;
                end
            end
            ST_POLL: begin
                // The synchroniser still shows the released line for two
                // clocks after select rises, so ready is not trusted yet
                gap_d = (gap_q < 16'(SK_HALF + 2)) ? gap_q + 16'h1 : gap_q;
                if (din_s2_q && gap_q == 16'(SK_HALF + 2)) begin
                    // Memory ready, or pin floating high with no memory
                    busy_d = 1'b0;
                    ev[`SEC_IRQ_DONE] = 1'b1;
                    state_d = ST_IDLE;
                end else if (tmo_cnt_q >= 32'(TIMEOUT_CYC - 1)) begin
                    busy_d = 1'b0;
                    tmo_d = 1'b1;
                    ev[`SEC_IRQ_TMO] = 1'b1;
                    state_d = ST_IDLE;
                end
            end
            ST_NEXT: begin
                if (idx_q == 9'h000 && byte_q != `SEC_SIGNATURE) begin
                    // Unprogrammed memory: nothing is written out
                    busy_d = 1'b0;
                    reload_d = 1'b0;
                    ev[`SEC_IRQ_DONE] = 1'b1;
                    state_d = ST_IDLE;
                end else begin
                    if (idx_q != 9'h000) begin
                        lwr_d = 1'b1;
                        laddr_d = idx_q;
                        ldata_d = byte_q;
                    end
                    if (idx_q == 9'(LOAD_BYTES - 1)) begin
                        loaded_d = 1'b1;
                        busy_d = 1'b0;
                        reload_d = 1'b0;
                        ev[`SEC_IRQ_DONE] = 1'b1;
                        ev[`SEC_IRQ_LOAD] = 1'b1;
                        state_d = ST_IDLE;
                    end else begin
                        idx_d = idx_q + 9'h1;
                        gap_d = 16'h0;
                        state_d = ST_GAP;
                    end
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase

        // Select is high only while a frame or a ready poll is on the wire
        cs_d = (state_d == ST_SEND) || (state_d == ST_POLL);

        // Sticky events: a new event wins over a write-one clear
        ists_d = (ists_q & ~(wr_ists ? reg_wdata[`SEC_IRQ_W-1:0] : '0)) | ev;
        imsk_d = wr_imsk ? reg_wdata[`SEC_IRQ_W-1:0] : imsk_q;
    end

    // Read data is valid only in the cycle after the strobe
    always_comb begin
        rdata_d = 32'h0;
        if (reg_rd) begin
            case (reg_addr)
                `SEC_CMD_OFS: begin
                    rdata_d[`SEC_BUSY_BIT] = busy_q;
                    rdata_d[`SEC_OP_HI:`SEC_OP_LO] = op_q;
                    rdata_d[`SEC_TMO_BIT] = tmo_q;
                    rdata_d[`SEC_LOADED_BIT] = loaded_q;
                    rdata_d[`SEC_ADDR_HI:0] = addr_q;
                end
                `SEC_DATA_OFS: rdata_d[`SEC_DATA_HI:0] = data_q;
                `SEC_ISTS_OFS: rdata_d[`SEC_IRQ_W-1:0] = ists_q;
                `SEC_IMSK_OFS: rdata_d[`SEC_IRQ_W-1:0] = imsk_q;
                default: rdata_d = 32'h0;
            endcase
        end
    end

    // Reset starts busy so the power-up load runs as a reload
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_q <= ST_IDLE;
            op_q <= CMD_READ;
            addr_q <= `SEC_ADDR_RST;
            data_q <= `SEC_DATA_RST;
            busy_q <= 1'b1;
            tmo_q <= 1'b0;
            loaded_q <= 1'b0;
            reload_q <= 1'b1;
            idx_q <= 9'h000;
            tmo_cnt_q <= 32'h0;
            gap_q <= 16'h0;
            byte_q <= 8'h00;
            start_q <= 1'b0;
            cs_q <= 1'b0;
            ists_q <= '0;
            imsk_q <= '0;
            rdata_q <= 32'h0;
            lwr_q <= 1'b0;
            laddr_q <= 9'h000;
            ldata_q <= 8'h00;
        end else begin
            state_q <= state_d;
            op_q <= op_d;
            addr_q <= addr_d;
            data_q <= data_d;
            busy_q <= busy_d;
            tmo_q <= tmo_d;
            loaded_q <= loaded_d;
            reload_q <= reload_d;
            idx_q <= idx_d;
            tmo_cnt_q <= tmo_cnt_d;
            gap_q <= gap_d;
            byte_q <= byte_d;
            start_q <= start_d;
            cs_q <= cs_d;
            ists_q <= ists_d;
            imsk_q <= imsk_d;
            rdata_q <= rdata_d;
            lwr_q <= lwr_d;
            laddr_q <= laddr_d;
            ldata_q <= ldata_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign mem_cs = cs_q;
    assign cfg_load_wr = lwr_q;
    assign cfg_load_addr = laddr_q;
    assign cfg_load_data = ldata_q;
    assign irq = |(ists_q & imsk_q);

endmodule

// ===== rtl/sec_shift.sv
`include "sec_regs.svh"

module sec_shift #(
    parameter int SK_HALF = `SEC_SK_HALF_CYC // Clocks per serial clock half
) (
    input logic clk, // System clock
    input logic reset_n, // Synchronous reset
    input logic start, // Pulse: begin a frame
    input logic [`SEC_FRAME_W-1:0] frame, // Bits to send, MSB first
    input logic [4:0] tx_len, // Bits to send
    input logic [3:0] rx_len, // Bits to receive after them
    input logic din, // Synchronised memory data output
    output logic sk, // Serial clock to memory
    output logic dout, // Serial data to memory
    output logic done, // Pulse: frame finished
    output logic [7:0] rx_byte // Bits received
);
    import sec_pkg::*;

    logic active_q, active_d;
    logic sk_q, sk_d;
    logic di_q, di_d;
    logic done_q, done_d;
    logic [15:0] div_q, div_d;
    logic [4:0] cnt_q, cnt_d;
    logic [`SEC_FRAME_W-1:0] sh_q, sh_d;
    logic [7:0] rx_q, rx_d;
    logic tick;

    // Divider gives one enable per serial clock half period
    assign tick = active_q && (div_q == 16'(SK_HALF - 1));

    // Data changes while the clock is low; the memory samples on its rise
    always_comb begin
        active_d = active_q;
        sk_d = sk_q;
        di_d = di_q;
        done_d = 1'b0;
        div_d = (active_q && !tick) ? div_q + 16'h0001 : 16'h0000;
        cnt_d = cnt_q;
        sh_d = sh_q;
        rx_d = rx_q;
        if (start && !active_q) begin
            active_d = 1'b1;
            sh_d = frame;
            cnt_d = tx_len + 5'(rx_len);
            di_d = frame[`SEC_FRAME_W-1];
            sk_d = 1'b0;
        end else if (tick) begin
            if (!sk_q) begin
                sk_d = 1'b1;
            end else begin
                // Sample at the end of the high phase, where data is settled
                sk_d = 1'b0;
                if (cnt_q <= 5'(rx_len)) begin
                    rx_d = {rx_q[6:0], din};
                end
                sh_d = {sh_q[`SEC_FRAME_W-2:0], 1'b0};
                di_d = sh_q[`SEC_FRAME_W-2];
                cnt_d = cnt_q - 5'd1;
                if (cnt_q == 5'd1) begin
                    active_d = 1'b0;
                    done_d = 1'b1;
                    di_d = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            active_q <= 1'b0;
            sk_q <= 1'b0;
            di_q <= 1'b0;
            done_q <= 1'b0;
            div_q <= 16'h0000;
            cnt_q <= 5'h00;
            sh_q <= '0;
            rx_q <= 8'h00;
        end else begin
            active_q <= active_d;
            sk_q <= sk_d;
            di_q <= di_d;
            done_q <= done_d;
            div_q <= div_d;
            cnt_q <= cnt_d;
            sh_q <= sh_d;
            rx_q <= rx_d;
        end
    end

    assign sk = sk_q;
    assign dout = di_q;
    assign done = done_q;
    assign rx_byte = rx_q;

endmodule
